// file: rtl/ocf_formatter.sv
// Output code formatter of the 10-bit converter: strobe capture, coding, over-range flag
`timescale 1ns/1ns
module ocf_formatter
   import ocf_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               sample_strobe,
   input  wire logic [10:0]        sampled_step,
   input  wire logic               msb_flip_select,
   input  wire logic               low_bits_flip_select,
   output ocf_pkg::ocf_result_s    result,
   output logic                    result_valid
);
   import ocf_pkg::*;

   // Pins other than sys_rst sampled twice before any logic reads them
   logic [2:0]  strobe_sync_r;
   logic [10:0] step_s1_r;
   logic [10:0] step_s2_r;
   logic [1:0]  msb_sync_r;
   logic [1:0]  low_sync_r;
   ocf_result_s result_r;
   logic        valid_r;

   always_ff @(posedge clk)
   begin
      strobe_sync_r <= {strobe_sync_r[1:0], sample_strobe};
      step_s1_r     <= sampled_step;
      step_s2_r     <= step_s1_r;
      msb_sync_r    <= {msb_sync_r[0], msb_flip_select};
      low_sync_r    <= {low_sync_r[0], low_bits_flip_select};
   end

   wire strobe_rise = strobe_sync_r[1] & ~strobe_sync_r[2];

   wire over_range = (step_s2_r >= OCF_STEP_OVER);

   wire [9:0] offset_code = over_range ? OCF_CODE_TOP : step_s2_r[9:0];

   // Selection mask kept apart from the recoder so checks do not reuse it
   wire [9:0] sel_mask = (msb_sync_r[1] ? OCF_MSB_MASK : OCF_CODE_ZERO)
                       | (low_sync_r[1] ? OCF_LOW_MASK : OCF_CODE_ZERO);

   wire [9:0] coded_word;
   ocf_recode u_recode
   (
      .code_in  (offset_code),
      .msb_flip (msb_sync_r[1]),
      .low_flip (low_sync_r[1]),
      .code_out (coded_word)
   );

   // Coding mode, for visibility only; selects are static in use
   wire ocf_coding_e coding = ocf_coding_e'({msb_sync_r[1] ^ low_sync_r[1], low_sync_r[1]});

   ocf_result_s result_nxt;
   assign result_nxt.word = coded_word;
   assign result_nxt.over = over_range;

   // Reset only clears the output stage; the converter itself has none
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         result_r <= '0;
         valid_r  <= 1'b0;
      end
      else
      begin
         valid_r <= strobe_rise;
         if (strobe_rise)
            result_r <= result_nxt;
      end
   end

   assign result       = result_r;
   assign result_valid = valid_r;

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_strobe_to_valid: assert property (strobe_rise |=> result_valid)
      else $error("valid missing after strobe");
   a_offset_binary: assert property (strobe_rise && !msb_sync_r[1] && !low_sync_r[1] && !over_range
      |=> result.word == $past(step_s2_r[9:0]))
      else $error("offset binary wrong");
   a_inverted_bin: assert property (strobe_rise && msb_sync_r[1] && low_sync_r[1] && !over_range
      |=> result.word == ~$past(step_s2_r[9:0]))
      else $error("inverted binary wrong");
   a_twos_comp: assert property (strobe_rise && msb_sync_r[1] && !low_sync_r[1] && !over_range
      |=> result.word == ($past(step_s2_r[9:0]) ^ OCF_MSB_MASK))
      else $error("two's complement wrong");
   a_inv_twos: assert property (strobe_rise && !msb_sync_r[1] && low_sync_r[1] && !over_range
      |=> result.word == ($past(step_s2_r[9:0]) ^ OCF_LOW_MASK))
      else $error("inverted two's complement wrong");
   a_top_saturate: assert property (strobe_rise && over_range && !msb_sync_r[1] && !low_sync_r[1]
      |=> result.word == OCF_CODE_TOP)
      else $error("no saturation");
   a_flag_set: assert property (strobe_rise |=> result.over == $past(step_s2_r[10]))
      else $error("over-range flag wrong");
   // Judged at capture: selects may move later while the word stands
   a_flag_only_over: assert property (strobe_rise && over_range
      |=> result.over && result.word == (OCF_CODE_TOP ^ $past(sel_mask)))
      else $error("flag with non-top word");
   a_flag_zero_in: assert property (strobe_rise && !over_range |=> !result.over)
      else $error("flag raised below over-range");
   a_valid_pulse: assert property (result_valid |=> !result_valid)
      else $error("valid longer than one cycle");
   a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> result == '0 && !result_valid)
      else $error("output stage not cleared by reset");
   a_hold_between: assert property (!strobe_rise |=> $stable(result))
      else $error("result changed without strobe");

   c_over_range: cover property (strobe_rise && over_range);
   c_twos_mode:  cover property (strobe_rise && coding == OCF_TWOS);
   c_back2back:  cover property (strobe_rise ##2 strobe_rise);
endmodule

// file: include/ocf_pkg.sv
// Package for the output code formatter: widths, codes and the result carrier
package ocf_pkg;
   localparam int  OCF_WIDTH      = 10;
   localparam int  OCF_MSB        = 9;
   localparam int  OCF_STEP_W     = 11;
   localparam logic [10:0] OCF_STEP_OVER = 11'h400;
   localparam logic [9:0]  OCF_CODE_TOP  = 10'h3ff;
   localparam logic [9:0]  OCF_CODE_ZERO = 10'h000;
   localparam logic [9:0]  OCF_LOW_MASK  = 10'h1ff;
   localparam logic [9:0]  OCF_MSB_MASK  = 10'h200;

   typedef enum logic [1:0] {
      OCF_OFFSET_BIN,
      OCF_INV_BIN,
      OCF_TWOS,
      OCF_INV_TWOS
   } ocf_coding_e;

   typedef struct packed {
      logic [9:0] word;
      logic       over;
   } ocf_result_s;
endpackage

// file: rtl/ocf_recode.sv
// Combinational recoding of an offset binary code into the selected coding
`timescale 1ns/1ns
module ocf_recode
   import ocf_pkg::*;
(
   input  wire logic [9:0] code_in,
   input  wire logic       msb_flip,
   input  wire logic       low_flip,
   output logic      [9:0] code_out
);
   wire [9:0] flip_mask = (msb_flip ? OCF_MSB_MASK : OCF_CODE_ZERO)
                        | (low_flip ? OCF_LOW_MASK : OCF_CODE_ZERO);
   assign code_out = code_in ^ flip_mask;
endmodule

// file: sim/ocf_capture.sv
// Downstream capture register for finished conversion words
`timescale 1ns/1ns
module ocf_capture
   import ocf_pkg::*;
(
   input  wire logic                 clk,
   input  wire ocf_pkg::ocf_result_s result,
   input  wire logic                 result_valid,
   output ocf_pkg::ocf_result_s      captured
);
   // flag kept raw
   // Flag is latched with the word, never used as a level measure
   always_ff @(posedge clk)
      if (result_valid)
         captured <= result;
endmodule

// file: sim/adc_output_code_formatter_test.sv
// Self-checking bench for the output code formatter
`timescale 1ns/1ns
module adc_output_code_formatter_test;
   import ocf_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        sample_strobe = 1'b0;
   logic [10:0] sampled_step = 11'h000;
   logic        msb_flip_select = 1'b0;
   logic        low_bits_flip_select = 1'b0;
   ocf_result_s result;
   ocf_result_s captured;
   logic        result_valid;
   int          err_count = 0;
   int          compares = 0;
   logic [10:0] steps [10] = '{11'h000, 11'h001, 11'h002, 11'h1fe, 11'h1ff, 11'h200, 11'h3fe, 11'h3ff, 11'h400, 11'h401};
   initial forever #50 clk = ~clk;
   ocf_formatter dut (.clk(clk), .sys_rst(sys_rst), .sample_strobe(sample_strobe), .sampled_step(sampled_step),
      .msb_flip_select(msb_flip_select), .low_bits_flip_select(low_bits_flip_select), .result(result),
      .result_valid(result_valid));
   ocf_capture cap (.clk(clk), .result(result), .result_valid(result_valid), .captured(captured));
   task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic convert(input logic [10:0] s, input logic m, input logic l);
      logic [10:0] e;
      int          n;
      e = {((s >= OCF_STEP_OVER) ? OCF_CODE_TOP : s[9:0]) ^ (m ? OCF_MSB_MASK : 10'h000)
           ^ (l ? OCF_LOW_MASK : 10'h000), s >= OCF_STEP_OVER};
      @(posedge clk);
      sampled_step <= s;
      msb_flip_select <= m;
      low_bits_flip_select <= l;
      repeat (3) @(posedge clk);
      sample_strobe <= 1'b1;
      for (n = 0; n < 8 && result_valid !== 1'b1; n++) @(negedge clk);
      cmp("valid", 11'h001, {10'h000, result_valid});
      cmp("result", e, result);
      @(posedge clk);
      sample_strobe <= 1'b0;
      @(negedge clk);
      cmp("valid pulse", 11'h000, {10'h000, result_valid});
      cmp("captured", e, captured);
   endtask
   task automatic test_reset;
      @(negedge clk);
      cmp("reset result", 11'h000, result);
      cmp("reset valid", 11'h000, {10'h000, result_valid});
      $display("test_reset done");
   endtask
   // Every coding over boundary steps; flag falls again on each wrap to step 0
   task automatic test_codes;
      for (int c = 0; c < 4; c++)
         for (int i = 0; i < 10; i++)
            convert(steps[i], c[1], c[0]);
      $display("test_codes done");
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      test_reset();
      test_codes();
      complete_run();
   end
   // About 325 cycles expected; 10000 cycles means a hang
   initial
   begin
      #1000000;
      err_count++;
      complete_run();
   end
endmodule
